// ===== core/ddrio_pkg.sv
// Shared constants for the per-pin DDR I/O register tile.
package ddrio_pkg;
    localparam int unsigned CLK_PERIOD_NS   = 50;
    localparam int unsigned DDR_MAX_MHZ     = 350;
    localparam int unsigned PAIR_W          = 2;
    localparam int unsigned DELAY_SEL_W     = 3;
    localparam int unsigned DELAY_TAPS      = 8;
    localparam logic [2:0]  DELAY_MIN_SEL   = 3'h0;
    localparam logic [2:0]  DELAY_MAX_SEL   = 3'h7;
    localparam logic        CLEAR_VALUE     = 1'h0;
    localparam logic        OE_N_RESET      = 1'h1;
    localparam logic [1:0]  PAIR_RESET      = 2'h0;
    localparam int unsigned PAIR_FALL_BIT   = 1;
    localparam int unsigned PAIR_RISE_BIT   = 0;
endpackage

// ===== core/ddrio_stream_if.sv
// Valid/ready carrier for captured input pairs between tile modules.
`timescale 1ns/10ps
`default_nettype none
interface ddrio_stream_if;
    logic                          valid;
    logic                          ready;
    logic [ddrio_pkg::PAIR_W-1:0]  data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== core/ddrio_skid.sv
// Two-entry buffer with registered outputs between capture and core.
`timescale 1ns/10ps
`default_nettype none
module ddrio_skid (
    input  wire logic                         core_clk_i,
    input  wire logic                         rst_i,
    ddrio_stream_if.snk                       up,
    input  wire logic                         dn_ready_i,
    output logic                              dn_valid_o,
    output logic [ddrio_pkg::PAIR_W-1:0]      dn_data_o
);
    logic                          out_valid_reg;
    logic                          out_valid_next;
    logic [ddrio_pkg::PAIR_W-1:0]  out_data_reg;
    logic [ddrio_pkg::PAIR_W-1:0]  out_data_next;
    logic                          skid_valid_reg;
    logic                          skid_valid_next;
    logic [ddrio_pkg::PAIR_W-1:0]  skid_data_reg;
    logic [ddrio_pkg::PAIR_W-1:0]  skid_data_next;
    logic                          take;
    logic                          pop;

    // A word may enter a full buffer in the cycle that the receiver drains one.
    assign up.ready   = !skid_valid_reg || pop;
    assign dn_valid_o = out_valid_reg;
    assign dn_data_o  = out_data_reg;

    always_comb begin
        pop             = out_valid_reg && dn_ready_i;
        take            = up.valid && (!skid_valid_reg || pop);
        out_valid_next  = out_valid_reg;
        out_data_next   = out_data_reg;
        skid_valid_next = skid_valid_reg;
        skid_data_next  = skid_data_reg;
        if (!out_valid_reg || pop) begin
            if (skid_valid_reg) begin
                out_valid_next  = 1'h1;
                out_data_next   = skid_data_reg;
                skid_valid_next = take;
                skid_data_next  = take ? up.data : skid_data_reg;
            end else begin
                out_valid_next = take;
                out_data_next  = take ? up.data : out_data_reg;
            end
        end else if (take) begin
            skid_valid_next = 1'h1;
            skid_data_next  = up.data;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_valid_reg  <= ddrio_pkg::CLEAR_VALUE;
            out_data_reg   <= ddrio_pkg::PAIR_RESET;
            skid_valid_reg <= ddrio_pkg::CLEAR_VALUE;
            skid_data_reg  <= ddrio_pkg::PAIR_RESET;
        end else begin
            out_valid_reg  <= out_valid_next;
            out_data_reg   <= out_data_next;
            skid_valid_reg <= skid_valid_next;
            skid_data_reg  <= skid_data_next;
        end
    end
endmodule
`default_nettype wire

// ===== core/ddrio_tile.sv
// Per-pin I/O register tile with single- and double-rate input and output.
`timescale 1ns/10ps
`default_nettype none
module ddrio_tile (
    input  wire logic                         core_clk_i,
    input  wire logic                         reset_i,
    input  wire logic                         shared_clear_preset_i,
    input  wire logic                         ddr_mode_i,
    input  wire logic                         delay_bypass_i,
    input  wire logic [2:0]                   delay_sel_i,
    input  wire logic                         pad_in_i,
    output logic                              pad_out_o,
    output logic                              pad_oe_n_o,
    input  wire logic                         core_out_rise_i,
    input  wire logic                         core_out_fall_i,
    input  wire logic                         core_oe_i,
    input  wire logic                         core_in_ready_i,
    output logic                              core_in_valid_o,
    output logic [ddrio_pkg::PAIR_W-1:0]      core_in_data_o,
    output logic                              in_overrun_o
);
    logic                          rst;
    logic                          cap_rise_reg;
    logic                          cap_rise_next;
    logic                          cap_fall_reg;
    logic                          cap_fall_next;
    logic                          cap_retime_reg;
    logic                          cap_retime_next;
    logic [ddrio_pkg::PAIR_W-1:0]  tap_reg [ddrio_pkg::DELAY_TAPS];
    logic [ddrio_pkg::PAIR_W-1:0]  tap_next [ddrio_pkg::DELAY_TAPS];
    logic [ddrio_pkg::PAIR_W-1:0]  pair_now;
    logic                          out_rise_reg;
    logic                          out_rise_next;
    logic                          out_fall_reg;
    logic                          out_fall_next;
    logic                          oe_n_reg;
    logic                          oe_n_next;
    logic                          overrun_reg;
    logic                          overrun_next;
    logic                          started_reg;
    logic                          started_next;

    ddrio_stream_if cap_if ();

    // Any clear source acts on every register except the falling-edge one.
    assign rst = reset_i | shared_clear_preset_i;

    always_comb begin
        cap_rise_next   = pad_in_i;
        cap_fall_next   = pad_in_i;
        cap_retime_next = cap_fall_reg;
    end

    always_ff @(posedge core_clk_i or posedge rst) begin
        if (rst) begin
            cap_rise_reg   <= ddrio_pkg::CLEAR_VALUE;
            cap_retime_reg <= ddrio_pkg::CLEAR_VALUE;
        end else begin
            cap_rise_reg   <= cap_rise_next;
            cap_retime_reg <= cap_retime_next;
        end
    end

    // The second input register has no clear so it keeps capturing.
    always_ff @(negedge core_clk_i) begin
        cap_fall_reg <= cap_fall_next;
    end

    // Single rate reports the rising sample in both pair bits.
    always_comb begin
        pair_now = '0;
        pair_now[ddrio_pkg::PAIR_RISE_BIT] = cap_rise_reg;
        pair_now[ddrio_pkg::PAIR_FALL_BIT] = ddr_mode_i ? cap_retime_reg : cap_rise_reg;
        tap_next[0] = pair_now;
        for (int i = 1; i < ddrio_pkg::DELAY_TAPS; i++) begin
            tap_next[i] = tap_reg[i-1];
        end
    end

    always_ff @(posedge core_clk_i or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < ddrio_pkg::DELAY_TAPS; i++) begin
                tap_reg[i] <= ddrio_pkg::PAIR_RESET;
            end
        end else begin
            for (int i = 0; i < ddrio_pkg::DELAY_TAPS; i++) begin
                tap_reg[i] <= tap_next[i];
            end
        end
    end

    // Setting 0 is the shortest tap and setting 7 the longest.
    assign cap_if.data  = delay_bypass_i ? pair_now : tap_reg[delay_sel_i];
    assign cap_if.valid = started_reg;

    ddrio_skid u_skid (
        .core_clk_i (core_clk_i),
        .rst_i      (rst),
        .up         (cap_if),
        .dn_ready_i (core_in_ready_i),
        .dn_valid_o (core_in_valid_o),
        .dn_data_o  (core_in_data_o)
    );

    always_comb begin
        out_rise_next = core_out_rise_i;
        out_fall_next = ddr_mode_i ? core_out_fall_i : core_out_rise_i;
        oe_n_next     = !core_oe_i;
        started_next  = 1'h1;
        overrun_next  = overrun_reg | (cap_if.valid & !cap_if.ready);
    end

    always_ff @(posedge core_clk_i or posedge rst) begin
        if (rst) begin
            out_rise_reg <= ddrio_pkg::CLEAR_VALUE;
            out_fall_reg <= ddrio_pkg::CLEAR_VALUE;
            oe_n_reg     <= ddrio_pkg::OE_N_RESET;
            overrun_reg  <= ddrio_pkg::CLEAR_VALUE;
            started_reg  <= ddrio_pkg::CLEAR_VALUE;
        end else begin
            out_rise_reg <= out_rise_next;
            out_fall_reg <= out_fall_next;
            oe_n_reg     <= oe_n_next;
            overrun_reg  <= overrun_next;
            started_reg  <= started_next;
        end
    end

    // High phase drives the first bit, low phase the second at double rate and the first at single rate; rated to 350 MHz.
    assign pad_out_o    = core_clk_i ? out_rise_reg : out_fall_reg;
    assign pad_oe_n_o   = oe_n_reg;
    assign in_overrun_o = overrun_reg;
endmodule
`default_nettype wire

// ===== verif/ddrio_pad_model.sv
// Far-side source that launches a new random pad bit on every clock edge.
`timescale 1ns/10ps
`default_nettype none
module ddrio_pad_model (
    input  wire logic clk_i,
    output var logic  pad_o
);
    integer seed = 32'he49a;
    initial pad_o = 1'h0;
    // A new bit a quarter period after each edge, so the sampling edges see it settled.
    always @(clk_i) pad_o <= #12.5 1'($random(seed));
endmodule
`default_nettype wire

// ===== verif/ddrio_tile_monitor.sv
// Concurrent checks on the ports of the DDR I/O register tile.
`timescale 1ns/10ps
`default_nettype none
module ddrio_tile_monitor (
    input wire logic       core_clk_i,
    input wire logic       reset_i,
    input wire logic       shared_clear_preset_i,
    input wire logic       ddr_mode_i,
    input wire logic       delay_bypass_i,
    input wire logic [2:0] delay_sel_i,
    input wire logic       pad_in_i,
    input wire logic       pad_out_o,
    input wire logic       pad_oe_n_o,
    input wire logic       core_out_rise_i,
    input wire logic       core_out_fall_i,
    input wire logic       core_oe_i,
    input wire logic       core_in_ready_i,
    input wire logic       core_in_valid_o,
    input wire logic [1:0] core_in_data_o,
    input wire logic       in_overrun_o
);
    logic rise_q, fall_q, clr;
    assign clr = reset_i || shared_clear_preset_i;
    // Copies of the output bits loaded on each rising edge.
    always_ff @(posedge core_clk_i or posedge clr) begin
        if (clr) begin
            rise_q <= 1'h0;
            fall_q <= 1'h0;
        end else begin
            rise_q <= core_out_rise_i;
            fall_q <= core_out_fall_i;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (clr);
    sequence s_held;
        core_in_valid_o && !core_in_ready_i;
    endsequence
    sequence s_flowing;
        core_in_valid_o && core_in_ready_i ##1 core_in_valid_o && core_in_ready_i;
    endsequence
    a_oe_from_req: assert property (1'h1 |=> pad_oe_n_o == !$past(core_oe_i))
        else $error("Enable does not follow the drive request.");
    a_high_phase: assert property (@(negedge core_clk_i) pad_out_o == rise_q)
        else $error("High phase does not show the rising bit.");
    a_low_phase: assert property (pad_out_o == (ddr_mode_i ? fall_q : rise_q))
        else $error("Low phase shows the wrong bit.");
    a_pair_held: assert property (s_held |=> core_in_valid_o && $stable(core_in_data_o))
        else $error("Stalled pair was not held.");
    a_flow_steady: assert property (s_flowing |=> core_in_valid_o)
        else $error("Pair stream broke while the core accepted.");
    a_overrun_kept: assert property (in_overrun_o |=> in_overrun_o)
        else $error("Overrun flag dropped.");
    a_overrun_cause: assert property ($rose(in_overrun_o) |-> !$past(core_in_ready_i))
        else $error("Overrun without a stall.");
    a_sdr_pair: assert property (!ddr_mode_i && core_in_valid_o |->
        core_in_data_o[1] == core_in_data_o[0])
        else $error("Single-rate pair bits differ.");
    a_clear_all: assert property (disable iff (reset_i) shared_clear_preset_i |->
        pad_oe_n_o && !core_in_valid_o && !in_overrun_o && !pad_out_o)
        else $error("Shared clear left a register set.");
endmodule
bind ddrio_tile ddrio_tile_monitor u_mon (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .shared_clear_preset_i(shared_clear_preset_i), .ddr_mode_i(ddr_mode_i),
    .delay_bypass_i(delay_bypass_i), .delay_sel_i(delay_sel_i), .pad_in_i(pad_in_i),
    .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o), .core_out_rise_i(core_out_rise_i),
    .core_out_fall_i(core_out_fall_i), .core_oe_i(core_oe_i),
    .core_in_ready_i(core_in_ready_i), .core_in_valid_o(core_in_valid_o),
    .core_in_data_o(core_in_data_o), .in_overrun_o(in_overrun_o));
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the DDR I/O register tile.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    logic            clk = 1'h0, rst = 1'h1, clr = 1'h0, ddr = 1'h1, byp = 1'h1, rdy = 1'h1;
    logic            o_r = 1'h0, o_f = 1'h0, oe = 1'h0, er, ef, eo, fall_s;
    logic [2:0]      sel = 3'h0;
    logic [1:0]      d0, hist [0:15];
    wire logic       pad, pout, poe_n, vld, ovr;
    wire logic [1:0] dat;
    integer          seed = 32'he49a, err_count = 0, cmp_count = 0, s;
    ddrio_pad_model pm (.clk_i(clk), .pad_o(pad));
    ddrio_tile dut (.core_clk_i(clk), .reset_i(rst), .shared_clear_preset_i(clr),
        .ddr_mode_i(ddr), .delay_bypass_i(byp), .delay_sel_i(sel), .pad_in_i(pad),
        .pad_out_o(pout), .pad_oe_n_o(poe_n), .core_out_rise_i(o_r), .core_out_fall_i(o_f),
        .core_oe_i(oe), .core_in_ready_i(rdy), .core_in_valid_o(vld),
        .core_in_data_o(dat), .in_overrun_o(ovr));
    initial forever #25 clk = ~clk;
    function automatic logic [1:0] exp_pair(input logic d, input logic fs, input logic rs);
        return {d ? fs : rs, rs};
    endfunction
    function automatic logic exp_low(input logic d, input logic r, input logic f);
        return d ? f : r;
    endfunction
    // Expected pairs, newest first, built from the pad levels at each edge.
    always @(negedge clk) fall_s <= pad;
    always @(posedge clk) begin
        for (int j = 15; j > 0; j--) hist[j] <= hist[j-1];
        hist[0] <= exp_pair(ddr, fall_s, pad);
    end
    task automatic run(input int n, input int lat);
        repeat (n) begin
            @(negedge clk);
            {er, ef, eo} = {o_r, o_f, oe};
            {o_r, o_f, oe} = 3'($random(seed));
            #12.5;
            `CHK({pout, poe_n}, {exp_low(ddr, er, ef), !eo})
            if (lat > 0) `CHK({vld, dat}, {1'h1, hist[lat]})
            @(posedge clk);
            #12.5;
            `CHK({pout, poe_n}, {o_r, !oe})
        end
    endtask
    task automatic cfg(input logic d, input logic b, input logic [2:0] v);
        @(negedge clk);
        {rst, ddr, byp, sel} = {1'h1, d, b, v};
        @(negedge clk);
        rst = 1'h0;
    endtask
    task print_verdict;
        if (err_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        // Every delay setting, then bypass, then single rate.
        for (s = 0; s < 10; s++) begin
            cfg(s != 9, s > 7, 3'(s));
            run(14, 0);
            run(20, s > 7 ? 1 : s + 2);
        end
        // A single stalled cycle is absorbed: one more cycle of latency, nothing lost.
        @(negedge clk);
        rdy = 1'h0;
        @(negedge clk);
        rdy = 1'h1;
        run(4, 2);
        `CHK(ovr, 1'h0)
        @(negedge clk);
        rdy = 1'h0;
        d0 = dat;
        repeat (4) @(negedge clk);
        `CHK({vld, dat, ovr}, {1'h1, d0, 1'h1})
        clr = 1'h1;
        #12.5;
        `CHK({vld, poe_n, ovr, pout}, 4'h4)
        @(negedge clk);
        {clr, rdy} = 2'h1;
        run(6, 0);
        run(16, 1);
        print_verdict();
    end
endmodule
`default_nettype wire
